// [bus_slave_ack.sv]
// Slave-side answer logic: transfer acknowledge, error acknowledge and retry.
`timescale 1ns/1ps
`include "lbm_params.svh"
module bus_slave_ack (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Sampled bus request
   input wire logic access_start,
   input wire logic access_read,
   input wire logic [`LBM_SIZE_W-1:0] access_size,
   // Core answers
   input wire logic write_taken,
   input wire logic read_valid,
   input wire logic access_error,
   input wire logic retry_request,
   input wire logic delayed_read_en,
   // Core view of the access
   output logic slave_access,
   output logic slave_read_q,
   output logic [`LBM_SIZE_W-1:0] slave_size_q,
   output logic read_come_back_q,
   // Answer pins
   output logic ack_out_q,
   output logic ack_oe_n_q,
   output logic error_out_q,
   output logic error_oe_n_q,
   output logic retry_out_q,
   output logic retry_oe_n_q
);
   import lbm_pkg::*;

   slave_state_t state_q;

   assign slave_access = (state_q == S_BUSY);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= S_IDLE;
         slave_read_q <= `LBM_DIR_WRITE;
         slave_size_q <= '0;
      end
      else
      begin
         unique case (state_q)
            S_IDLE:
               if (access_start)
               begin
                  state_q <= S_BUSY;
                  slave_read_q <= access_read;
                  slave_size_q <= access_size;
               end
            S_BUSY:
               if (access_error || retry_request || (slave_read_q ? read_valid : write_taken))
                  state_q <= S_REPLY;
            S_REPLY:
               state_q <= S_IDLE;
         endcase
      end
   end

   // Each answer is driven for one clock; the error and retry answers outrank the ack.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_out_q <= `LBM_PIN_IDLE;
         ack_oe_n_q <= `LBM_DRIVE_OFF;
         error_out_q <= `LBM_PIN_IDLE;
         error_oe_n_q <= `LBM_DRIVE_OFF;
         retry_out_q <= `LBM_PIN_IDLE;
         retry_oe_n_q <= `LBM_DRIVE_OFF;
      end
      else
      begin
         ack_out_q <= `LBM_PIN_IDLE;
         ack_oe_n_q <= `LBM_DRIVE_OFF;
         error_out_q <= `LBM_PIN_IDLE;
         error_oe_n_q <= `LBM_DRIVE_OFF;
         retry_out_q <= `LBM_PIN_IDLE;
         retry_oe_n_q <= `LBM_DRIVE_OFF;
         if (state_q == S_BUSY)
         begin
            if (access_error)
            begin
               error_out_q <= 1'h0;
               error_oe_n_q <= `LBM_DRIVE_ON;
            end
            else if (retry_request)
            begin
               retry_out_q <= 1'h0;
               retry_oe_n_q <= `LBM_DRIVE_ON;
            end
            else if (slave_read_q ? read_valid : write_taken)
            begin
               ack_out_q <= 1'h0;
               ack_oe_n_q <= `LBM_DRIVE_ON;
            end
         end
      end
   end

   // A retried read in delayed-read mode leaves the data pending until the master reissues it.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         read_come_back_q <= 1'h0;
      else if (state_q == S_BUSY && !access_error && retry_request && slave_read_q
               && delayed_read_en)
         read_come_back_q <= 1'h1;
      else if (state_q == S_IDLE && access_start && access_read)
         read_come_back_q <= 1'h0;
   end
endmodule

// [bus_target_model.sv]
// Local bus target that answers the bridge's own master accesses.
`timescale 1ns/1ps
module bus_target_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Bridge strobe and test controls
   input wire logic start_n,
   input wire logic start_oe_n,
   input wire logic [1:0] wait_cycles,
   input wire logic fault,
   // Answer pins, driven high between answers
   output logic ack_n,
   output logic err_n
);
   logic busy_q;
   logic [1:0] cnt_q;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_q <= 1'h0;
         cnt_q <= 2'h0;
         ack_n <= 1'h1;
         err_n <= 1'h1;
      end
      else
      begin
         ack_n <= 1'h1;
         err_n <= 1'h1;
         if (!start_n && !start_oe_n)
         begin
            busy_q <= 1'h1;
            cnt_q <= wait_cycles;
         end
         else if (busy_q && cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
         else if (busy_q)
         begin
            busy_q <= 1'h0;
            ack_n <= fault;
            err_n <= !fault;
         end
      end
   end
endmodule

// [lbm_checker_sva.sv]
// Concurrent checks on the ports of the local bus signalling block.
`timescale 1ns/1ps
module lbm_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Master side
   input wire logic master_request,
   input wire logic master_grant,
   input wire logic master_busy,
   input wire logic master_read,
   input wire logic [1:0] master_size,
   input wire logic transfer_start_n_out,
   input wire logic transfer_start_n_oe_n,
   input wire logic read_write_out,
   input wire logic [1:0] transfer_size_out,
   // Slave side
   input wire logic slave_access,
   input wire logic slave_read,
   input wire logic write_taken,
   input wire logic read_valid,
   input wire logic access_error,
   input wire logic retry_request,
   input wire logic transfer_ack_n_out,
   input wire logic transfer_ack_n_oe_n,
   input wire logic transfer_error_ack_n_out,
   input wire logic transfer_error_ack_n_oe_n,
   input wire logic retry_n_out,
   input wire logic retry_n_oe_n,
   // Multiplexed pin
   input wire lbm_pkg::mux_role_t mux_role,
   input wire logic master_fifo_full,
   input wire logic xfer_request_n_out,
   input wire logic xfer_request_n_oe_n
);
   import lbm_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   chk_start_on_take: assert property (master_request && master_grant && !master_busy
      |=> !transfer_start_n_out && !transfer_start_n_oe_n) else $error("no start strobe");
   chk_start_one_clk: assert property (!transfer_start_n_out && !transfer_start_n_oe_n
      |=> transfer_start_n_out) else $error("start strobe held");
   chk_dir_at_start: assert property (!transfer_start_n_out && !transfer_start_n_oe_n
      |-> read_write_out == $past(master_read)) else $error("wrong direction");
   chk_size_at_start: assert property (!transfer_start_n_out && !transfer_start_n_oe_n
      |-> transfer_size_out == $past(master_size)) else $error("wrong size");
   chk_ack_on_answer: assert property (slave_access && !access_error && !retry_request
      && (slave_read ? read_valid : write_taken)
      |=> !transfer_ack_n_out && !transfer_ack_n_oe_n) else $error("no acknowledge");
   chk_error_on_fault: assert property (slave_access && access_error
      |=> !transfer_error_ack_n_out && !transfer_error_ack_n_oe_n) else $error("no error ack");
   chk_retry_on_request: assert property (slave_access && retry_request && !access_error
      |=> !retry_n_out && !retry_n_oe_n) else $error("no retry");
   chk_request_role: assert property ($past(mux_role) == ROLE_REQUEST && $past(rst_n)
      |-> xfer_request_n_out == $past(master_fifo_full) && !xfer_request_n_oe_n)
      else $error("request pin wrong");
endmodule

bind local_bus_m_mode_signals lbm_checker u_lbm_checker (.*);

// [lbm_params.svh]
// Timing counts, field widths, encodings and reset values of the local bus signalling block.
`ifndef LBM_PARAMS_SVH
`define LBM_PARAMS_SVH

`define LBM_SYNC_STAGES 3
`define LBM_LEVEL_W 6
`define LBM_SIZE_W 2
`define LBM_ROLE_W 2
`define LBM_ROLE_REQUEST 2'h0
`define LBM_ROLE_ALMOST_FULL 2'h1
`define LBM_ROLE_END_OF_TRANSFER 2'h2
`define LBM_PIN_IDLE 1'h1
`define LBM_DRIVE_OFF 1'h1
`define LBM_DRIVE_ON 1'h0
`define LBM_DIR_READ 1'h1
`define LBM_DIR_WRITE 1'h0

`endif

// [lbm_pkg.sv]
// Types shared by the local bus signalling modules.
package lbm_pkg;
   typedef enum logic [1:0] {ROLE_REQUEST, ROLE_ALMOST_FULL, ROLE_END_OF_TRANSFER} mux_role_t;
   typedef enum {M_IDLE, M_START, M_WAIT} master_state_t;
   typedef enum {S_IDLE, S_BUSY, S_REPLY} slave_state_t;
endpackage

// [local_bus_m_mode_signals.sv]
// Local bus control signalling of the bridge in processor-bus mode.
`timescale 1ns/1ps
`include "lbm_params.svh"
module local_bus_m_mode_signals #(
   parameter int LEVEL_W = `LBM_LEVEL_W
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Straps and configuration
   input wire logic host_role_strap_n,
   input wire logic core_reset_hold,
   input wire lbm_pkg::mux_role_t mux_role,
   input wire logic [LEVEL_W-1:0] almost_full_threshold,
   input wire logic lock_role,
   input wire logic delayed_read_en,
   // Local reset pin and bus reset request
   input wire logic local_reset_n_in,
   output logic local_reset_n_out,
   output logic local_reset_n_oe_n,
   output logic pci_reset_request,
   // Multiplexed request, almost-full and end-of-transfer pin
   input wire logic xfer_request_n_in,
   output logic xfer_request_n_out,
   output logic xfer_request_n_oe_n,
   // Master FIFO and DMA state
   input wire logic master_fifo_full,
   input wire logic [LEVEL_W-1:0] master_fifo_level,
   input wire logic dma_active,
   input wire logic dma_channel,
   output logic dma_terminate,
   output logic dma_terminate_channel,
   // Power management
   input wire logic power_event_request_n,
   input wire logic d3cold_state,
   output logic power_event,
   // User and lock input
   input wire logic general_input,
   output logic general_input_value,
   output logic lock_hold,
   // Bus control pins
   input wire logic transfer_start_n_in,
   output logic transfer_start_n_out,
   output logic transfer_start_n_oe_n,
   input wire logic read_write_in,
   output logic read_write_out,
   output logic read_write_oe_n,
   input wire logic [`LBM_SIZE_W-1:0] transfer_size_in,
   output logic [`LBM_SIZE_W-1:0] transfer_size_out,
   output logic transfer_size_oe_n,
   input wire logic transfer_ack_n_in,
   output logic transfer_ack_n_out,
   output logic transfer_ack_n_oe_n,
   input wire logic transfer_error_ack_n_in,
   output logic transfer_error_ack_n_out,
   output logic transfer_error_ack_n_oe_n,
   output logic retry_n_out,
   output logic retry_n_oe_n,
   input wire logic slave_select,
   // Core slave side
   input wire logic write_taken,
   input wire logic read_valid,
   input wire logic access_error,
   input wire logic retry_request,
   output logic slave_access,
   output logic slave_read,
   output logic [`LBM_SIZE_W-1:0] slave_size,
   output logic read_come_back,
   // Core master side
   input wire logic master_grant,
   input wire logic master_request,
   input wire logic master_read,
   input wire logic [`LBM_SIZE_W-1:0] master_size,
   output logic master_busy,
   output logic master_done,
   output logic master_error
);
   import lbm_pkg::*;

   logic strap_n_s;
   logic reset_in_s;
   logic power_req_s;
   logic general_s;
   logic eot_q;
   logic eot_prev_q;
   master_state_t mstate_q;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   pin_sync #(.RESET_VAL(`LBM_PIN_IDLE)) strap_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin(host_role_strap_n),
      .level_q(strap_n_s)
   );

   pin_sync #(.RESET_VAL(`LBM_PIN_IDLE)) reset_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin(local_reset_n_in),
      .level_q(reset_in_s)
   );

   pin_sync #(.RESET_VAL(`LBM_PIN_IDLE)) power_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin(power_event_request_n),
      .level_q(power_req_s)
   );

   pin_sync #(.RESET_VAL(`LBM_PIN_IDLE)) general_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin(general_input),
      .level_q(general_s)
   );

   // ----------------------------------------
   // Local reset pin
   // ----------------------------------------
   // The pin drives low during reset, then follows core_reset_hold while the strap is high and is released while it is low.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         local_reset_n_out <= 1'h0;
         local_reset_n_oe_n <= `LBM_DRIVE_ON;
         pci_reset_request <= 1'h0;
      end
      else if (!strap_n_s)
      begin
         local_reset_n_out <= `LBM_PIN_IDLE;
         local_reset_n_oe_n <= `LBM_DRIVE_OFF;
         pci_reset_request <= !reset_in_s;
      end
      else
      begin
         local_reset_n_out <= !core_reset_hold;
         local_reset_n_oe_n <= `LBM_DRIVE_ON;
         pci_reset_request <= 1'h0;
      end
   end

   // ----------------------------------------
   // Multiplexed request pin
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xfer_request_n_out <= `LBM_PIN_IDLE;
         xfer_request_n_oe_n <= `LBM_DRIVE_OFF;
      end
      else
      begin
         unique case (mux_role)
            ROLE_REQUEST:
            begin
               xfer_request_n_out <= master_fifo_full;
               xfer_request_n_oe_n <= `LBM_DRIVE_ON;
            end
            ROLE_ALMOST_FULL:
            begin
               xfer_request_n_out <= (master_fifo_level >= almost_full_threshold);
               xfer_request_n_oe_n <= `LBM_DRIVE_ON;
            end
            default:
            begin
               xfer_request_n_out <= `LBM_PIN_IDLE;
               xfer_request_n_oe_n <= `LBM_DRIVE_OFF;
            end
         endcase
      end
   end

   // The terminate input is a synchronous bus signal, so one register suffices.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         eot_q <= `LBM_PIN_IDLE;
         eot_prev_q <= `LBM_PIN_IDLE;
      end
      else
      begin
         eot_q <= (mux_role == ROLE_END_OF_TRANSFER) ? xfer_request_n_in : `LBM_PIN_IDLE;
         eot_prev_q <= eot_q;
      end
   end

   // One terminate pulse per assertion, aimed at whichever channel is running.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dma_terminate <= 1'h0;
         dma_terminate_channel <= 1'h0;
      end
      else
      begin
         dma_terminate <= !eot_q && eot_prev_q && dma_active;
         dma_terminate_channel <= dma_channel;
      end
   end

   // ----------------------------------------
   // Power event, user and lock inputs
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power_event <= 1'h0;
         general_input_value <= 1'h0;
         lock_hold <= 1'h0;
      end
      else
      begin
         power_event <= !power_req_s && d3cold_state;
         general_input_value <= lock_role ? 1'h0 : general_s;
         lock_hold <= lock_role && !general_s && (master_busy || master_request);
      end
   end

   // ----------------------------------------
   // Bridge as local bus master
   // ----------------------------------------
   assign master_busy = (mstate_q != M_IDLE);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         mstate_q <= M_IDLE;
      else
      begin
         unique case (mstate_q)
            M_IDLE:
               if (master_request && master_grant)
                  mstate_q <= M_START;
            M_START:
               mstate_q <= M_WAIT;
            M_WAIT:
               if (!transfer_ack_n_in || !transfer_error_ack_n_in)
                  mstate_q <= M_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         transfer_start_n_out <= `LBM_PIN_IDLE;
         transfer_start_n_oe_n <= `LBM_DRIVE_OFF;
         read_write_out <= `LBM_DIR_READ;
         read_write_oe_n <= `LBM_DRIVE_OFF;
         transfer_size_out <= '0;
         transfer_size_oe_n <= `LBM_DRIVE_OFF;
      end
      else if (mstate_q == M_IDLE && master_request && master_grant)
      begin
         transfer_start_n_out <= 1'h0;
         transfer_start_n_oe_n <= `LBM_DRIVE_ON;
         read_write_out <= master_read ? `LBM_DIR_READ : `LBM_DIR_WRITE;
         read_write_oe_n <= `LBM_DRIVE_ON;
         transfer_size_out <= master_size;
         transfer_size_oe_n <= `LBM_DRIVE_ON;
      end
      else if (mstate_q == M_START)
         transfer_start_n_out <= `LBM_PIN_IDLE;
      else if (mstate_q == M_WAIT && (!transfer_ack_n_in || !transfer_error_ack_n_in))
      begin
         transfer_start_n_oe_n <= `LBM_DRIVE_OFF;
         read_write_oe_n <= `LBM_DRIVE_OFF;
         transfer_size_oe_n <= `LBM_DRIVE_OFF;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         master_done <= 1'h0;
         master_error <= 1'h0;
      end
      else
      begin
         master_done <= (mstate_q == M_WAIT) && !transfer_ack_n_in && transfer_error_ack_n_in;
         master_error <= (mstate_q == M_WAIT) && !transfer_error_ack_n_in;
      end
   end

   // ----------------------------------------
   // Bridge as local bus slave
   // ----------------------------------------
   bus_slave_ack slave (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .access_start(!transfer_start_n_in && slave_select && !master_busy),
      .access_read(read_write_in == `LBM_DIR_READ),
      .access_size(transfer_size_in),
      .write_taken(write_taken),
      .read_valid(read_valid),
      .access_error(access_error),
      .retry_request(retry_request),
      .delayed_read_en(delayed_read_en),
      .slave_access(slave_access),
      .slave_read_q(slave_read),
      .slave_size_q(slave_size),
      .read_come_back_q(read_come_back),
      .ack_out_q(transfer_ack_n_out),
      .ack_oe_n_q(transfer_ack_n_oe_n),
      .error_out_q(transfer_error_ack_n_out),
      .error_oe_n_q(transfer_error_ack_n_oe_n),
      .retry_out_q(retry_n_out),
      .retry_oe_n_q(retry_n_oe_n)
   );
endmodule

// [pin_sync.sv]
// Three-stage synchroniser for a pin that comes from outside the clock domain.
`timescale 1ns/1ps
`include "lbm_params.svh"
module pin_sync #(
   parameter logic RESET_VAL = `LBM_PIN_IDLE
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Pin and filtered level
   input wire logic pin,
   output logic level_q
);
   logic meta_q;
   logic mid_q;
   logic last_q;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= RESET_VAL;
         mid_q <= RESET_VAL;
         last_q <= RESET_VAL;
      end
      else
      begin
         meta_q <= pin;
         mid_q <= meta_q;
         last_q <= mid_q;
      end
   end

   // A change counts only once the second and third stages agree.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         level_q <= RESET_VAL;
      else if (mid_q == last_q)
         level_q <= last_q;
   end
endmodule

// [tb.sv]
// Self-checking bench for the local bus signalling block.
`timescale 1ns/1ps
module tb;
   import lbm_pkg::*;
   logic core_clk = 1'h0;
   logic rst_n, host_role_strap_n, core_reset_hold, lock_role, delayed_read_en;
   logic local_reset_n_in, xfer_request_n_in, master_fifo_full, dma_active, dma_channel;
   logic power_event_request_n, d3cold_state, general_input, read_write_in, slave_select;
   logic write_taken, read_valid, access_error, retry_request, master_grant, master_request;
   logic master_read, ts_n, fault;
   logic [1:0] transfer_size_in, master_size, tgt_wait, transfer_size_out, slave_size;
   logic [5:0] almost_full_threshold, master_fifo_level;
   mux_role_t mux_role;
   logic local_reset_n_out, local_reset_n_oe_n, pci_reset_request, xfer_request_n_out;
   logic xfer_request_n_oe_n, dma_terminate, dma_terminate_channel, power_event, lock_hold;
   logic general_input_value, transfer_start_n_out, transfer_start_n_oe_n, read_write_out;
   logic read_write_oe_n, transfer_size_oe_n, transfer_ack_n_out, transfer_ack_n_oe_n;
   logic transfer_error_ack_n_out, transfer_error_ack_n_oe_n, retry_n_out, retry_n_oe_n;
   logic slave_access, slave_read, read_come_back, master_busy, master_done, master_error;
   wire transfer_ack_n_in, transfer_error_ack_n_in;
   wire transfer_start_n_in = transfer_start_n_oe_n ? ts_n : transfer_start_n_out;
   logic [31:0] seed = 32'h4ddb;
   logic [4:0] q[$];
   logic [4:0] ev;
   logic [2:0] hits;
   logic got_ch;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;

   local_bus_m_mode_signals u_local_bus_m_mode_signals (.*);
   bus_target_model u_bus_target_model (.core_clk(core_clk), .rst_n(rst_n),
      .start_n(transfer_start_n_out), .start_oe_n(transfer_start_n_oe_n),
      .wait_cycles(tgt_wait), .fault(fault), .ack_n(transfer_ack_n_in),
      .err_n(transfer_error_ack_n_in));

   always #2.5 core_clk = !core_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic mst(input logic rd, input logic [1:0] sz, input logic flt);
      tick(1);
      {master_request, master_grant, master_read, master_size, fault} = {2'h3, rd, sz, flt};
      tgt_wait = 2'(rnd());
      q.push_back(flt ? 5'h08 : 5'h10);
      tick(1);
      master_request = 1'h0;
      cmp("start", 8'h0, {transfer_start_n_out, transfer_start_n_oe_n});
      cmp("dir", rd, read_write_out);
      cmp("size", sz, transfer_size_out);
      cmp("drive", 8'h4, {master_busy, read_write_oe_n, transfer_size_oe_n});
      for (int i = 0; i < 12 && master_busy !== 1'h0; i++)
         tick(1);
      cmp("release", 8'h7, {transfer_start_n_oe_n, read_write_oe_n, transfer_size_oe_n});
   endtask

   task automatic slv(input logic rd, input logic [1:0] sz, input logic [1:0] ans);
      tick(1);
      {ts_n, slave_select, read_write_in, transfer_size_in} = {2'h1, rd, sz};
      tick(1);
      {ts_n, slave_select} = 2'h2;
      cmp("slave", {2'h1, rd, sz}, {slave_access, slave_read, slave_size});
      {write_taken, read_valid} = {!rd && ans == 0, rd && ans == 0};
      {access_error, retry_request} = {ans == 1, ans == 2};
      q.push_back(ans == 0 ? 5'h04 : (ans == 1 ? 5'h02 : 5'h01));
      tick(1);
      {write_taken, read_valid, access_error, retry_request} = 4'h0;
      tick(2);
      cmp("come_back", rd && ans == 2 && delayed_read_en, read_come_back);
   endtask

   // ----------------------------------------
   // Result monitor
   // ----------------------------------------
   always @(negedge core_clk)
   begin
      ev = {master_done, master_error, !(transfer_ack_n_out | transfer_ack_n_oe_n),
         !(transfer_error_ack_n_out | transfer_error_ack_n_oe_n), !(retry_n_out | retry_n_oe_n)};
      if (ev !== 5'h0)
         cmp("event", q.size() > 0 ? q.pop_front() : 5'h0, ev);
   end

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst_n, core_reset_hold, lock_role, delayed_read_en, dma_active} = '0;
      {master_fifo_full, dma_channel, d3cold_state, general_input, read_write_in} = '0;
      {slave_select, write_taken, read_valid, access_error, retry_request} = '0;
      {master_grant, master_request, master_read, fault, master_size, tgt_wait} = '0;
      {host_role_strap_n, local_reset_n_in, xfer_request_n_in, power_event_request_n, ts_n} = '1;
      {transfer_size_in, almost_full_threshold, master_fifo_level} = '0;
      mux_role = ROLE_REQUEST;
      tick(2);
      cmp("lrst", 8'h0, {local_reset_n_out, local_reset_n_oe_n});
      tick(2);
      rst_n = 1'h1;
      tick(6);
      for (int i = 0; i < 8; i++)
         mst(1'(rnd()), 2'(i), i > 5);
      for (int i = 0; i < 12; i++)
      begin
         delayed_read_en = i > 5;
         slv(1'(i / 3), 2'(rnd()), 2'(i % 3));
      end
      slv(1'h1, 2'(rnd()), 2'h0);
      for (int i = 0; i < 2; i++)
      begin
         master_fifo_full = 1'(i);
         tick(2);
         cmp("req_pin", {1'(i), 1'h0}, {xfer_request_n_out, xfer_request_n_oe_n});
      end
      mux_role = ROLE_ALMOST_FULL;
      almost_full_threshold = 6'(rnd() % 40 + 8);
      for (int i = 0; i < 2; i++)
      begin
         master_fifo_level = i ? almost_full_threshold + 6'h8 : almost_full_threshold - 6'h8;
         tick(2);
         cmp("af_pin", 8'(i), xfer_request_n_out);
      end
      mux_role = ROLE_END_OF_TRANSFER;
      for (int i = 0; i < 2; i++)
      begin
         {dma_active, dma_channel, hits, got_ch} = {1'(i), 1'(rnd()), 4'h0};
         tick(1);
         xfer_request_n_in = 1'h0;
         for (int k = 0; k < 5; k++)
         begin
            tick(1);
            hits += 3'(dma_terminate);
            got_ch |= dma_terminate & dma_terminate_channel;
         end
         xfer_request_n_in = 1'h1;
         cmp("terminate", {1'(i), 1'(i) & dma_channel}, {hits, got_ch});
      end
      for (int i = 0; i < 2; i++)
      begin
         {d3cold_state, power_event_request_n, general_input} = {1'(i), 1'h0, 1'(i)};
         tick(6);
         cmp("pme", 8'(i), power_event);
         cmp("user", 8'(i), general_input_value);
         power_event_request_n = 1'h1;
         tick(6);
      end
      {lock_role, general_input, master_grant, master_request} = 4'h9;
      tick(6);
      cmp("lock", 8'h2, {lock_hold, general_input_value});
      {lock_role, master_request, core_reset_hold} = 3'h1;
      tick(2);
      cmp("lrst_hold", 8'h0, {local_reset_n_out, local_reset_n_oe_n});
      core_reset_hold = 1'h0;
      for (int i = 0; i < 2; i++)
      begin
         {host_role_strap_n, local_reset_n_in} = {1'(i), 1'h0};
         tick(8);
         cmp("pci_rst", !i, pci_reset_request);
         local_reset_n_in = 1'h1;
         tick(6);
         cmp("pci_rst_off", 8'h0, pci_reset_request);
      end
      tick(4);
      cmp("pending", 8'h0, 8'(q.size()));
      print_verdict();
   end
endmodule
